// file: tone_pair_steering_latch.sv
// steering, guard time and output latch of a dual-tone receiver
// What this block does
// [R01] power-down pin is active high; it stops the oscillator and powers down.
// [R02] system supplies the 3.579545 MHz reference that times the detection logic.
// [R03] all four code lines are driven while the output enable is high.
// [R04] all four code lines float while the output enable is low.
// [R05] output enable is pulled up, so outputs are enabled when undriven.
// [R06] enabled code lines show the latch holding the last validated pair.
// [R07] early steer rises as soon as a valid tone pair is judged present.
// [R08] early steer falls at once when the valid pair is judged gone.
// [R09] system links early steer through a guard network to the steering pin.
// [R10] after each early steer change the steering pin is released and watched.
// [R11] when the watched level crosses the threshold, the pin is driven to early steer.
// [R12] steering pin fully high loads the new code and raises delayed steer.
// [R13] steering pin fully low drops delayed steer and re-arms for the next pair.
// [R14] zero-crossing square waves of both tone groups are brought out for test.
// [R15] table select picks one of two 4-bit encodings of the sixteen keys.
// [R16] threshold comparator result is synchronised before it steers anything.
// [R17] reset or power-down clears the latch and holds both steer outputs low.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module tone_pair_steering_latch (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // register port
    input wire logic [tone_pkg::REG_AW-1:0] reg_addr,
    input wire logic [tone_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [tone_pkg::REG_DW-1:0] reg_rdata,
    output logic irq,
    // detector decision
    input wire logic pair_valid,
    input wire logic [3:0] pair_code,
    // pins in
    input wire logic power_down_in,
    input wire logic tristate_output_enable,
    input wire logic table_select,
    input wire logic steer_threshold,
    input wire logic high_group_zero_cross,
    input wire logic low_group_zero_cross,
    input wire logic xtal_in,
    // pins out
    output logic xtal_out,
    output logic early_steer_out,
    output logic delayed_steer_out,
    output logic steer_guard_out,
    output logic steer_guard_oe,
    output tone_pkg::code_bus_s code_bus,
    output logic high_group_square_out,
    output logic low_group_square_out
);

    // ==========================================================
    // declarations
    logic [tone_pkg::PIN_COUNT-1:0] pins_raw;
    logic [tone_pkg::PIN_COUNT-1:0] pins;
    logic ctrl_soft_pd;
    logic powered_down;
    logic thr;
    tone_pkg::steer_state_e state;
    tone_pkg::steer_state_e next_state;
    logic ev_load;
    logic ev_drop;
    logic ev_early;
    logic [3:0] pending_code;
    logic [3:0] code_latch;
    logic [tone_pkg::EV_W-1:0] status;
    logic [tone_pkg::EV_W-1:0] mask;
    logic [tone_pkg::EV_W-1:0] next_status;
    logic [tone_pkg::EV_W-1:0] next_mask;
    logic [tone_pkg::EV_W-1:0] status_clear;
    logic [tone_pkg::REG_DW-1:0] code_word;

    // ==========================================================
    // key encoding
    function automatic logic [3:0] encode_key(input logic [3:0] std_code, input logic alt);
        logic [3:0] result;
        result = std_code;
        if (alt)
        begin
            if (std_code == tone_pkg::KEY_ZERO_STD)
                result = tone_pkg::KEY_ZERO_ALT;
            else if (std_code == tone_pkg::KEY_D_STD || std_code >= tone_pkg::KEY_STAR_STD)
                result = std_code - tone_pkg::KEY_STEP;
        end
        return result;
    endfunction

    // ==========================================================
    // pin synchronisers
    assign pins_raw = {xtal_in, low_group_zero_cross, high_group_zero_cross, steer_threshold,
                       table_select, tristate_output_enable, power_down_in};

    pin_synchronizer #(
        .WIDTH(tone_pkg::PIN_COUNT),
        .RESET_VALUE(tone_pkg::PIN_RESET) // [R05]
    ) u_pins (
        .clock(clock),
        .resetn(resetn),
        .pin_in(pins_raw),
        .level_out(pins)
    );

    assign powered_down = pins[tone_pkg::PIN_PD] | ctrl_soft_pd; // [R01]
    assign thr = pins[tone_pkg::PIN_THR]; // [R16]

    // ==========================================================
    // oscillator and test squares
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            xtal_out <= 1'b0;
            high_group_square_out <= 1'b0;
            low_group_square_out <= 1'b0;
        end
        else if (powered_down)
        begin
            xtal_out <= 1'b0; // [R01]
            high_group_square_out <= 1'b0;
            low_group_square_out <= 1'b0;
        end
        else
        begin
            xtal_out <= ~pins[tone_pkg::PIN_XTAL];
            high_group_square_out <= pins[tone_pkg::PIN_HZC]; // [R14]
            low_group_square_out <= pins[tone_pkg::PIN_LZC]; // [R14]
        end
    end

    // ==========================================================
    // early steer and pending code
    assign ev_early = pair_valid & ~early_steer_out & ~powered_down;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            early_steer_out <= 1'b0;
        else if (powered_down)
            early_steer_out <= 1'b0; // [R17]
        else
            early_steer_out <= pair_valid; // [R07] [R08]
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            pending_code <= tone_pkg::CODE_RESET;
        else if (powered_down)
            pending_code <= tone_pkg::CODE_RESET;
        else if (ev_early)
            pending_code <= pair_code;
    end

    // ==========================================================
    // steering state machine
    always_comb
    begin
        next_state = state;
        ev_load = 1'b0;
        ev_drop = 1'b0;
        unique case (state)
            tone_pkg::S_HELD_LOW:
            begin
                if (early_steer_out)
                    next_state = tone_pkg::S_RISING; // [R10]
            end
            tone_pkg::S_RISING:
            begin
                if (thr && early_steer_out)
                begin
                    next_state = tone_pkg::S_HELD_HIGH; // [R11]
                    ev_load = 1'b1;
                end
                else if (!thr && !early_steer_out)
                    next_state = tone_pkg::S_HELD_LOW; // [R11]
            end
            tone_pkg::S_HELD_HIGH:
            begin
                if (!early_steer_out)
                    next_state = tone_pkg::S_FALLING; // [R10]
            end
            tone_pkg::S_FALLING:
            begin
                if (!thr && !early_steer_out)
                begin
                    next_state = tone_pkg::S_HELD_LOW; // [R11]
                    ev_drop = 1'b1;
                end
                else if (thr && early_steer_out)
                    next_state = tone_pkg::S_HELD_HIGH; // [R11]
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= tone_pkg::S_HELD_LOW;
            steer_guard_oe <= 1'b1;
            steer_guard_out <= 1'b0;
        end
        else if (powered_down)
        begin
            state <= tone_pkg::S_HELD_LOW;
            steer_guard_oe <= 1'b1;
            steer_guard_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            steer_guard_oe <= (next_state == tone_pkg::S_HELD_LOW) ||
                              (next_state == tone_pkg::S_HELD_HIGH); // [R10] [R11]
            steer_guard_out <= (next_state == tone_pkg::S_HELD_HIGH); // [R11]
        end
    end

    // ==========================================================
    // output latch and delayed steer
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            code_latch <= tone_pkg::CODE_RESET;
            delayed_steer_out <= 1'b0;
        end
        else if (powered_down)
        begin
            code_latch <= tone_pkg::CODE_RESET; // [R17]
            delayed_steer_out <= 1'b0;
        end
        else if (ev_load)
        begin
            code_latch <= encode_key(pending_code, pins[tone_pkg::PIN_SEL]); // [R12] [R15]
            delayed_steer_out <= 1'b1; // [R12]
        end
        else if (ev_drop)
            delayed_steer_out <= 1'b0; // [R13]
    end

    // ==========================================================
    // code outputs
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            code_bus <= tone_pkg::code_bus_s'({tone_pkg::CODE_RESET, 1'b1});
        else
            code_bus <= tone_pkg::code_bus_s'({code_latch, pins[tone_pkg::PIN_TOE]}); // [R03] [R04] [R06]
    end

    // ==========================================================
    // registers
    assign status_clear = (reg_write && reg_addr == tone_pkg::ADDR_STATUS) ?
                          reg_wdata[tone_pkg::EV_W-1:0] : tone_pkg::EV_RESET;

    always_comb
    begin
        next_status = (status & ~status_clear) | {ev_early, ev_drop, ev_load};
        next_mask = mask;
        if (reg_write && reg_addr == tone_pkg::ADDR_MASK)
            next_mask = reg_wdata[tone_pkg::EV_W-1:0];
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            ctrl_soft_pd <= 1'b0;
        else if (reg_write && reg_addr == tone_pkg::ADDR_CTRL)
            ctrl_soft_pd <= reg_wdata[tone_pkg::CTRL_SOFT_PD_BIT];
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            status <= tone_pkg::EV_RESET;
            mask <= tone_pkg::EV_RESET;
            irq <= 1'b0;
        end
        else
        begin
            status <= next_status;
            mask <= next_mask;
            irq <= |(next_status & next_mask);
        end
    end

    always_comb
    begin
        code_word = '0;
        code_word[tone_pkg::CODE_LATCH_LSB +: 4] = code_latch;
        code_word[tone_pkg::CODE_STD_BIT] = delayed_steer_out;
        code_word[tone_pkg::CODE_EARLY_BIT] = early_steer_out;
        code_word[tone_pkg::CODE_STATE_LSB +: 2] = state;
        code_word[tone_pkg::CODE_PD_BIT] = powered_down;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= '0;
        else if (reg_read)
        begin
            unique case (reg_addr)
                tone_pkg::ADDR_CTRL: reg_rdata <= {{(tone_pkg::REG_DW-1){1'b0}}, ctrl_soft_pd};
                tone_pkg::ADDR_STATUS: reg_rdata <= {{(tone_pkg::REG_DW-tone_pkg::EV_W){1'b0}}, status};
                tone_pkg::ADDR_MASK: reg_rdata <= {{(tone_pkg::REG_DW-tone_pkg::EV_W){1'b0}}, mask};
                tone_pkg::ADDR_CODE: reg_rdata <= code_word;
                default: reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end

    // ==========================================================
    // assertions
    a_pd_osc_stop: assert property (@(posedge clock) disable iff (!resetn) // [R01]
        powered_down |=> !xtal_out && !high_group_square_out)
        else $error("oscillator output ran during power-down");

    a_code_driven: assert property (@(posedge clock) disable iff (!resetn) // [R03]
        pins[tone_pkg::PIN_TOE] |=> code_bus.oe)
        else $error("code lines not driven with enable high");

    a_code_float: assert property (@(posedge clock) disable iff (!resetn) // [R04]
        !pins[tone_pkg::PIN_TOE] |=> !code_bus.oe)
        else $error("code lines driven with enable low");

    a_code_value: assert property (@(posedge clock) disable iff (!resetn) // [R06]
        code_bus.oe |-> ({code_bus.code_bit3, code_bus.code_bit2,
                          code_bus.code_bit1, code_bus.code_bit0} == $past(code_latch)))
        else $error("code lines differ from latch");

    a_early_follow: assert property (@(posedge clock) disable iff (!resetn) // [R07]
        (pair_valid && !powered_down) |=> early_steer_out)
        else $error("early steer missed a valid pair");

    a_early_drop: assert property (@(posedge clock) disable iff (!resetn) // [R08]
        !pair_valid |=> !early_steer_out)
        else $error("early steer stayed high without a valid pair");

    a_pin_release: assert property (@(posedge clock) disable iff (!resetn) // [R10]
        (state == tone_pkg::S_HELD_LOW && early_steer_out && !powered_down)
        |=> !steer_guard_oe ##1 (!steer_guard_oe || thr))
        else $error("steering pin not released after early steer change");

    a_pin_drive: assert property (@(posedge clock) disable iff (!resetn) // [R11]
        (state == tone_pkg::S_RISING && thr && early_steer_out && !powered_down)
        |=> steer_guard_oe && steer_guard_out)
        else $error("steering pin not driven high after threshold crossing");

    a_load_std: assert property (@(posedge clock) disable iff (!resetn) // [R12]
        $rose(delayed_steer_out) |-> $past(state) == tone_pkg::S_RISING && steer_guard_out)
        else $error("delayed steer rose without the pin going high");

    a_table_map: assert property (@(posedge clock) disable iff (!resetn) // [R15]
        $rose(delayed_steer_out)
        |-> code_latch == encode_key($past(pending_code), $past(pins[tone_pkg::PIN_SEL])))
        else $error("latched code does not match the chosen table");

    a_std_fall: assert property (@(posedge clock) disable iff (!resetn) // [R13]
        (state == tone_pkg::S_FALLING && !thr && !early_steer_out && !powered_down)
        |=> !delayed_steer_out && state == tone_pkg::S_HELD_LOW && !steer_guard_out)
        else $error("delayed steer did not drop with the pin low");

    a_square_out: assert property (@(posedge clock) disable iff (!resetn) // [R14]
        (!powered_down && pins[tone_pkg::PIN_LZC]) |=> low_group_square_out)
        else $error("low group square wave not passed out");

    a_pd_clear: assert property (@(posedge clock) disable iff (!resetn) // [R17]
        powered_down |=> code_latch == tone_pkg::CODE_RESET && !early_steer_out
                         && !delayed_steer_out)
        else $error("power-down did not clear latch and steer outputs");

endmodule

`default_nettype wire

// file: tone_pkg.sv
// shared constants, states and carriers of the tone pair steering latch
package tone_pkg;

    // ==========================================================
    // register port
    localparam int REG_AW = 4;
    localparam int REG_DW = 32;
    localparam logic [REG_AW-1:0] ADDR_CTRL = 4'h0;
    localparam logic [REG_AW-1:0] ADDR_STATUS = 4'h4;
    localparam logic [REG_AW-1:0] ADDR_MASK = 4'h8;
    localparam logic [REG_AW-1:0] ADDR_CODE = 4'hC;

    // ==========================================================
    // control and event fields
    localparam int CTRL_SOFT_PD_BIT = 0;
    localparam int EV_W = 3;
    localparam int EV_LOADED = 0;
    localparam int EV_DROPPED = 1;
    localparam int EV_EARLY = 2;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

    // ==========================================================
    // code register layout
    localparam int CODE_LATCH_LSB = 0;
    localparam int CODE_STD_BIT = 4;
    localparam int CODE_EARLY_BIT = 5;
    localparam int CODE_STATE_LSB = 6;
    localparam int CODE_PD_BIT = 8;

    // ==========================================================
    // pin synchroniser lanes
    localparam int PIN_PD = 0;
    localparam int PIN_TOE = 1;
    localparam int PIN_SEL = 2;
    localparam int PIN_THR = 3;
    localparam int PIN_HZC = 4;
    localparam int PIN_LZC = 5;
    localparam int PIN_XTAL = 6;
    localparam int PIN_COUNT = 7;
    // pulled-up pins rest high
    localparam logic [PIN_COUNT-1:0] PIN_RESET = 7'h03;

    // ==========================================================
    // key codes
    localparam logic [3:0] CODE_RESET = 4'h0;
    localparam logic [3:0] KEY_ZERO_STD = 4'hA;
    localparam logic [3:0] KEY_STAR_STD = 4'hB;
    localparam logic [3:0] KEY_D_STD = 4'h0;
    localparam logic [3:0] KEY_ZERO_ALT = 4'h0;
    localparam logic [3:0] KEY_STEP = 4'h1;

    // ==========================================================
    // types
    typedef enum logic [1:0]
    {
        S_HELD_LOW = 2'b00,
        S_RISING = 2'b01,
        S_HELD_HIGH = 2'b10,
        S_FALLING = 2'b11
    } steer_state_e;

    typedef struct packed
    {
        logic code_bit3;
        logic code_bit2;
        logic code_bit1;
        logic code_bit0;
        logic oe;
    } code_bus_s;

endpackage

// file: pin_synchronizer.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module pin_synchronizer #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // pins
    input wire logic [WIDTH-1:0] pin_in,
    // filtered levels
    output logic [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] agree;

    assign agree = ~(stage2 ^ stage3);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
            level_out <= RESET_VALUE;
        end
        else
        begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level_out <= (stage3 & agree) | (level_out & ~agree); // [R16]
        end
    end

    a_sync_agree: assert property (@(posedge clock) disable iff (!resetn) // [R16]
        (stage2 == stage3) |=> (level_out == $past(stage3)))
        else $error("synchronised level did not follow agreeing stages");

    a_sync_hold: assert property (@(posedge clock) disable iff (!resetn) // [R16]
        (stage2 != stage3) |=> $stable(level_out))
        else $error("synchronised level moved while stages disagreed");

endmodule

`default_nettype wire

// file: guard_network_model.sv
// guard time network and threshold comparator seen from the steering pin
`timescale 1ns/1ns
`default_nettype none

module guard_network_model #(
    parameter int CHARGE_MAX = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // steering link
    input wire logic early_steer,
    input wire logic pin_drive,
    input wire logic pin_oe,
    // comparator
    output logic threshold
);
    // ==========================================================
    // capacitor charge on the steering pin
    int charge;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            charge <= 0;
        else if (pin_oe)
            charge <= pin_drive ? CHARGE_MAX : 0;
        else if (early_steer && charge < CHARGE_MAX)
            charge <= charge + 1;
        else if (!early_steer && charge > 0)
            charge <= charge - 1;
    end

    assign threshold = charge > CHARGE_MAX / 2;
endmodule
`default_nettype wire

// file: test_tone_pair_steering_latch.sv
// self-checking testbench of the tone pair steering latch
`timescale 1ns/1ns
`default_nettype none

module test_tone_pair_steering_latch;
    logic clock, resetn, reg_write, reg_read, irq, pair_valid;
    logic [tone_pkg::REG_AW-1:0] reg_addr;
    logic [tone_pkg::REG_DW-1:0] reg_wdata, reg_rdata, rd;
    logic [3:0] pair_code;
    logic power_down_in, tristate_output_enable, table_select, steer_threshold;
    logic high_group_zero_cross, low_group_zero_cross, xtal_in, xtal_out;
    logic early_steer_out, delayed_steer_out, steer_guard_out, steer_guard_oe;
    logic high_group_square_out, low_group_square_out;
    tone_pkg::code_bus_s code_bus;
    logic [3:0] code_seen;
    int fails, total_checks;

    assign code_seen = {code_bus.code_bit3, code_bus.code_bit2, code_bus.code_bit1,
        code_bus.code_bit0};

    tone_pair_steering_latch tone_pair_steering_latch_i (.clock, .resetn, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq, .pair_valid, .pair_code,
        .power_down_in, .tristate_output_enable, .table_select, .steer_threshold,
        .high_group_zero_cross, .low_group_zero_cross, .xtal_in, .xtal_out,
        .early_steer_out, .delayed_steer_out, .steer_guard_out, .steer_guard_oe,
        .code_bus, .high_group_square_out, .low_group_square_out);

    guard_network_model guard_network_model_i (.clock, .resetn,
        .early_steer(early_steer_out), .pin_drive(steer_guard_out),
        .pin_oe(steer_guard_oe), .threshold(steer_threshold));

    // ==========================================================
    // clock and shared tasks
    always #50 clock = ~clock;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        rd = reg_rdata;
    endtask

    task automatic wait_std(input logic v);
        int n;
        n = 0;
        while (delayed_steer_out !== v && n < 60)
        begin
            tick(1);
            n++;
        end
    endtask

    task automatic press(input logic [3:0] c, input logic [3:0] exp);
        @(posedge clock);
        pair_code <= c;
        pair_valid <= 1'b1;
        tick(1);
        check(early_steer_out, 1'b1);
        tick(1);
        check(steer_guard_oe, 1'b0);
        wait_std(1'b1);
        check(delayed_steer_out, 1'b1);
        check({steer_guard_oe, steer_guard_out}, 2'b11);
        tick(1);
        check(code_seen, exp);
        @(posedge clock);
        pair_valid <= 1'b0;
        tick(1);
        check(early_steer_out, 1'b0);
        wait_std(1'b0);
        check(delayed_steer_out, 1'b0);
        check({steer_guard_oe, steer_guard_out}, 2'b10);
        tick(3);
    endtask

    function automatic logic [3:0] alt_of(input logic [3:0] s);
        if (s == 4'h0)
            return 4'hF;
        if (s == 4'hA)
            return 4'h0;
        if (s > 4'hA)
            return s - 4'h1;
        return s;
    endfunction

    // ==========================================================
    // scenarios
    task automatic t_reset;
        check(code_bus.oe, 1'b1);
        check({early_steer_out, delayed_steer_out, code_seen}, 6'h00);
        reg_rd(tone_pkg::ADDR_CODE);
        check(rd, 32'h100);
        @(posedge clock);
        pair_valid <= 1'b1;
        tick(5);
        check({early_steer_out, xtal_out}, 2'b00);
        reg_rd(4'h2);
        check(rd, 32'h0);
        @(posedge clock);
        pair_valid <= 1'b0;
        power_down_in <= 1'b0;
        tick(6);
        check(xtal_out, 1'b1);
        $display("test reset and power-down done");
    endtask

    task automatic t_irq;
        reg_wr(tone_pkg::ADDR_MASK, 32'h1);
        press(4'h5, 4'h5);
        check(irq, 1'b1);
        reg_rd(tone_pkg::ADDR_STATUS);
        check(rd, 32'h7);
        reg_rd(tone_pkg::ADDR_CODE);
        check(rd, 32'h5);
        reg_wr(tone_pkg::ADDR_STATUS, 32'h7);
        check(irq, 1'b0);
        reg_wr(tone_pkg::ADDR_MASK, 32'h0);
        press(4'h3, 4'h3);
        check(irq, 1'b0);
        reg_wr(tone_pkg::ADDR_MASK, 32'h2);
        check(irq, 1'b1);
        reg_wr(tone_pkg::ADDR_STATUS, 32'h7);
        reg_rd(tone_pkg::ADDR_STATUS);
        check(rd, 32'h0);
        $display("test interrupt done");
    endtask

    task automatic t_tables;
        for (int t = 0; t < 2; t++)
        begin
            @(posedge clock);
            table_select <= t[0];
            tick(5);
            for (int c = 0; c < 16; c++)
                press(c[3:0], t == 1 ? alt_of(c[3:0]) : c[3:0]);
        end
        $display("test code tables done");
    endtask

    task automatic t_abort;
        @(posedge clock);
        pair_code <= 4'h9;
        pair_valid <= 1'b1;
        tick(2);
        @(posedge clock);
        pair_valid <= 1'b0;
        tick(20);
        check({delayed_steer_out, code_seen}, 5'h0E);
        check({steer_guard_oe, steer_guard_out}, 2'b10);
        $display("test aborted pair done");
    endtask

    task automatic t_pins;
        @(posedge clock);
        tristate_output_enable <= 1'b0;
        high_group_zero_cross <= 1'b1;
        xtal_in <= 1'b1;
        tick(5);
        check(code_bus.oe, 1'b0);
        check(xtal_out, 1'b0);
        check({high_group_square_out, low_group_square_out}, 2'b10);
        @(posedge clock);
        tristate_output_enable <= 1'b1;
        high_group_zero_cross <= 1'b0;
        low_group_zero_cross <= 1'b1;
        xtal_in <= 1'b0;
        tick(5);
        check(code_bus.oe, 1'b1);
        check({high_group_square_out, low_group_square_out}, 2'b01);
        check(xtal_out, 1'b1);
        reg_wr(tone_pkg::ADDR_CTRL, 32'h1);
        reg_rd(tone_pkg::ADDR_CTRL);
        check(rd, 32'h1);
        reg_rd(tone_pkg::ADDR_CODE);
        check(rd, 32'h100);
        check(code_seen, 4'h0);
        check({xtal_out, low_group_square_out}, 2'b00);
        reg_wr(tone_pkg::ADDR_CTRL, 32'h0);
        $display("test pins done");
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        clock = 1'b0;
        resetn = 1'b0;
        {reg_write, reg_read, pair_valid, table_select} = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        pair_code = 4'h0;
        power_down_in = 1'b1;
        tristate_output_enable = 1'b1;
        {high_group_zero_cross, low_group_zero_cross, xtal_in} = 3'h0;
        fails = 0;
        total_checks = 0;
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        tick(1);
        t_reset();
        t_irq();
        t_tables();
        t_abort();
        t_pins();
        complete_run();
    end

    initial
    begin
        #1000000;
        fails++;
        complete_run();
    end
endmodule
`default_nettype wire
